// *** inc/eapor_pkg.sv ***
// Shared constants of the external and power-on reset logic
package eapor_pkg;
  // Device clock period
  localparam int CLK_PERIOD_NS = 20;
  // Least low time on the reset pin that counts as a reset
  localparam int FILT_TIME_NS  = 200;
  // Length of the on-chip power-on reset pulse
  localparam int POR_TIME_NS   = 2000;
  // Least time rounds up, never below one cycle
  localparam int FILT_CYC_RAW  =
    (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC      = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam int POR_CYC_RAW   =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CYC       = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
  // Power-on status flag value forced by a power-on reset
  localparam logic POR_FLAG_RST = 1'b0;
  // Power-on status flag position in the reset control register
  localparam int POR_FLAG_BIT   = 1;
endpackage

// *** design/eapor_reset.sv ***
`timescale 1ns/1ps
module eapor_reset #(
  parameter int FILT_CYCLES = eapor_pkg::FILT_CYC,
  parameter int POR_CYCLES  = eapor_pkg::POR_CYC
) (
  // Clock and supply-detect reset
  input  wire logic mclk,
  input  wire logic rst,
  // Board reset pin and its configuration bit
  input  wire logic external_reset_pin,
  input  wire logic external_reset_pin_enable,
  output logic      external_reset_pin_out,
  output logic      external_reset_pin_oe,
  output logic      pin_digital_in,
  // Other internal reset source: the watchdog timer
  input  wire logic watchdog_timer_reset_req,
  // Software write to the power-on status flag
  input  wire logic por_flag_wr,
  input  wire logic por_flag_wdata,
  // Reset network and status
  output logic      core_reset,
  output logic      power_on_reset_pulse,
  output logic      por_flag
);
  import eapor_pkg::*;

  localparam int FW = $clog2(FILT_CYCLES + 1);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam logic [FW-1:0] FILT_MAX = FW'(FILT_CYCLES);
  localparam logic [PW-1:0] POR_MAX  = PW'(POR_CYCLES);

  logic          pin_s1_r;    // First synchroniser stage
  logic          pin_s2_r;    // Second synchroniser stage
  logic [FW-1:0] low_cnt_r;   // Consecutive low samples
  logic          ext_low_r;   // Filtered pin reset level
  logic [PW-1:0] por_cnt_r;   // Power-on pulse cycles left
  logic          por_flag_r;  // Power-on status flag
  logic          din_r;       // Digital input view of the pin

  // Pin is an input only; nothing inside ever drives it
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe  = 1'b0;

  // Two-stage synchroniser on the pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= external_reset_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Noise filter: count low samples, release at once on high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
      ext_low_r <= 1'b0;
    end else if (pin_s2_r) begin
      // High sample ends any short pulse
      low_cnt_r <= '0;
      ext_low_r <= 1'b0;
    end else if (low_cnt_r < FILT_MAX - FW'(1)) begin
      // Low, but not yet long enough
      low_cnt_r <= low_cnt_r + FW'(1);
    end else begin
      // Low long enough: pin reset stands
      low_cnt_r <= FILT_MAX;
      ext_low_r <= 1'b1;
    end
  end

  // Digital input view, reads zero while pin acts as reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      din_r <= 1'b0;
    end else begin
      din_r <= external_reset_pin_enable ? 1'b0 : pin_s2_r;
    end
  end
  assign pin_digital_in = din_r;

  // Power-on pulse: stretched after the supply detect releases
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      por_cnt_r <= POR_MAX;
    end else if (por_cnt_r != '0) begin
      por_cnt_r <= por_cnt_r - PW'(1);
    end
  end
  assign power_on_reset_pulse = rst | (por_cnt_r != '0);

  // Status flag: cleared by power-on or a software write of zero, set only by software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      por_flag_r <= POR_FLAG_RST;
    end else if (por_cnt_r != '0) begin
      // Still inside the power-on pulse
      por_flag_r <= POR_FLAG_RST;
    end else if (por_flag_wr) begin
      // Software write, the only way back to one
      por_flag_r <= por_flag_wdata;
    end
    // Watchdog or pin resets leave it untouched
  end
  assign por_flag = por_flag_r;

  // Core reset: any active source
  assign core_reset = power_on_reset_pulse
                    | (ext_low_r & external_reset_pin_enable)
                    | watchdog_timer_reset_req;

  // ---- Checks ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Helper: consecutive low synchronised samples, saturating
  logic [FW:0] run_h;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_h <= '0;
    end else if (pin_s2_r) begin
      run_h <= '0;
    end else if (run_h <= {1'b0, FILT_MAX}) begin
      run_h <= run_h + (FW+1)'(1);
    end
  end

  // Helper: cycles since supply detect release, saturating
  logic [PW:0] age_h;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      age_h <= '0;
    end else if (age_h <= {1'b0, POR_MAX}) begin
      age_h <= age_h + (PW+1)'(1);
    end
  end

  // A full low run with the reset enabled must hold the core
  AST_PIN_LOW_RESETS: assert property (
    external_reset_pin_enable && run_h >= (FW+1)'(FILT_CYCLES)
    |-> core_reset)
    else $error("Enabled pin reset did not reset the core");
  AST_SHORT_PULSE_IGNORED: assert property (
    ext_low_r |-> run_h >= (FW+1)'(FILT_CYCLES))
    else $error("Short low pulse passed the filter");
  AST_PIN_NEVER_DRIVEN: assert property (
    !external_reset_pin_oe && !external_reset_pin_out)
    else $error("Reset pin was driven");
  AST_DISABLED_NO_RESET: assert property (
    !external_reset_pin_enable && !power_on_reset_pulse
    && !watchdog_timer_reset_req |-> !core_reset)
    else $error("Disabled pin caused a reset");
  AST_POR_LENGTH: assert property (
    power_on_reset_pulse == (age_h < (PW+1)'(POR_CYCLES)))
    else $error("Power-on pulse length wrong");
  AST_POR_CLEARS_FLAG: assert property (
    power_on_reset_pulse |=> !por_flag)
    else $error("Power-on reset did not clear flag");
  AST_OTHER_KEEPS_FLAG: assert property (
    (watchdog_timer_reset_req || ext_low_r) && !por_flag_wr
    && !power_on_reset_pulse |=> $stable(por_flag))
    else $error("Non power-on reset changed flag");
  AST_ONLY_SW_SETS: assert property (
    $rose(por_flag) |-> $past(por_flag_wr) && $past(por_flag_wdata))
    else $error("Flag set without software write");
  AST_POR_RESETS_CORE: assert property (
    power_on_reset_pulse || watchdog_timer_reset_req |-> core_reset)
    else $error("Reset source did not reset core");

  // Timing of the filter, the digital view and the flag; watchdog kept off the pin
  // Filter sets the pin reset on exactly the full low count
  AST_FILTER_COUNT: assert property (
    !pin_s2_r && run_h == (FW+1)'(FILT_CYCLES - 1) |=> ext_low_r)
    else $error("Filter did not set after the full low count");
  // A low run shorter than the filter never resets the core
  AST_SHORT_RUN_NO_RESET: assert property (
    !power_on_reset_pulse && !watchdog_timer_reset_req
    && run_h < (FW+1)'(FILT_CYCLES) |-> !core_reset)
    else $error("Short low run reset the core");
  // Pin reset drops on the first high sample
  AST_PIN_RELEASE: assert property (
    pin_s2_r |=> !ext_low_r)
    else $error("Pin reset outlived the pin low level");
  // Digital view follows the synchronised pin when reset is off
  AST_DIN_FOLLOWS: assert property (
    !external_reset_pin_enable |=> pin_digital_in == $past(pin_s2_r))
    else $error("Digital input does not follow the pin");
  // Digital view reads zero while the pin is a reset
  AST_DIN_ZERO: assert property (
    external_reset_pin_enable |=> !pin_digital_in)
    else $error("Digital input not zero in reset mode");
  // Write outside the power-on pulse lands one cycle later
  AST_FLAG_WRITE: assert property (
    por_flag_wr && !power_on_reset_pulse
    |=> por_flag == $past(por_flag_wdata))
    else $error("Software write to flag was lost");
  // Flag reads zero as the power-on pulse ends
  AST_FLAG_LOW_AFTER_POR: assert property (
    $fell(power_on_reset_pulse) |-> !por_flag)
    else $error("Flag not zero after power-on pulse");
  // Watchdog reset never reaches the pin
  AST_WDOG_NOT_ON_PIN: assert property (
    watchdog_timer_reset_req |-> !external_reset_pin_oe)
    else $error("Watchdog reset drove the pin");

  // Main scenarios the bench is expected to reach
  COV_POR_END: cover property ($fell(power_on_reset_pulse));
  COV_PIN_RESET: cover property (
    external_reset_pin_enable && $rose(ext_low_r));
  COV_SHORT_PULSE: cover property (
    !pin_s2_r ##1 pin_s2_r && !ext_low_r);
  COV_SW_SETS_FLAG: cover property ($rose(por_flag));
  COV_DIGITAL_INPUT: cover property (
    !external_reset_pin_enable && $rose(pin_digital_in));
endmodule

// *** bench/eapor_board.sv ***
`timescale 1ns/1ps
// Board side of the reset pin: a button to ground with a pull-up
module eapor_board (
  // Clock and request
  input  wire logic mclk,
  input  wire logic hold,
  // Pin level seen by the device
  output logic      pin
);
  // Released pin goes to the pull-up level, pressed pin to ground
  // Taken on the rising edge, a half cycle after the bench moves it
  always_ff @(posedge mclk) begin
    pin <= ~hold;
  end
endmodule

// *** bench/eapor_reset_tb.sv ***
`timescale 1ns/1ps
module eapor_reset_tb;
  import eapor_pkg::*;
  localparam int FC = 4;  // Short filter count
  localparam int PC = 8;  // Short power-on stretch
  logic mclk = 0, rst = 1, en = 1, hold = 0, wdog = 0, wr = 0, wd = 0;
  logic pin, pout, poe, din, core, pulse, flag;
  int   error_cnt = 0, total_checks = 0, cyc = 0;
  // Clock
  always #10 mclk = ~mclk;
  eapor_board i_eapor_board (.mclk(mclk), .hold(hold), .pin(pin));
  eapor_reset #(.FILT_CYCLES(FC), .POR_CYCLES(PC)) i_eapor_reset (
    .mclk(mclk), .rst(rst), .external_reset_pin(pin),
    .external_reset_pin_enable(en), .external_reset_pin_out(pout),
    .external_reset_pin_oe(poe), .pin_digital_in(din),
    .watchdog_timer_reset_req(wdog), .por_flag_wr(wr),
    .por_flag_wdata(wd), .core_reset(core),
    .power_on_reset_pulse(pulse), .por_flag(flag));
  // Compare one value and count it
  task chk(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Wait on falling edges
  task wn(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Verdict
  task end_sim;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Power-on pulse, flag cleared, write during pulse ignored
  task t_por;
    chk(core, 1'b1);
    chk(pulse, 1'b1);
    chk(flag, POR_FLAG_RST);
    rst = 0; wr = 1; wd = 1;
    wn(1);
    wr = 0;
    wn(PC + 2);
    chk(flag, 1'b0);
    chk(pulse, 1'b0);
    chk(core, 1'b0);
    $display("t_por done");
  endtask
  // Software sets flag; watchdog resets core but not flag or pin
  task t_wdog;
    wr = 1; wd = 1;
    wn(1);
    wr = 0;
    chk(flag, 1'b1);
    wdog = 1;
    wn(1);
    chk(core, 1'b1);
    chk(poe, 1'b0);
    chk(pout, 1'b0);
    wdog = 0;
    wn(1);
    chk(core, 1'b0);
    chk(flag, 1'b1);
    $display("t_wdog done");
  endtask
  // Short pulse filtered, long press resets, flag kept
  task t_pin;
    hold = 1; wn(2); hold = 0; wn(FC + 4);
    chk(core, 1'b0);
    hold = 1; wn(FC + 4);
    chk(core, 1'b1);
    chk(poe, 1'b0);
    chk(pout, 1'b0);
    hold = 0; wn(4);
    chk(core, 1'b0);
    chk(flag, 1'b1);
    $display("t_pin done");
  endtask
  // Disabled pin is a plain input; second power-on clears flag
  task t_dis;
    en = 0; wn(5);
    chk(din, 1'b1);
    hold = 1; wn(FC + 4);
    chk(core, 1'b0);
    chk(din, 1'b0);
    hold = 0; wn(5);
    chk(din, 1'b1);
    rst = 1; wn(2);
    chk(core, 1'b1);
    chk(flag, 1'b0);
    rst = 0; wn(PC + 3);
    chk(pulse, 1'b0);
    chk(flag, 1'b0);
    $display("t_dis done");
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    wn(20);
    t_por();
    t_wdog();
    t_pin();
    t_dis();
    end_sim();
  end
endmodule
